//--- hw/dram_strobe_map.sv
// dram strobe mapping, lane steering, row address slicing and page hit check
// Function
// - area 4 row strobe pin one, area 5 pin two
// - 16-bit 2cas/1we: column pins are low/high cas
// - 16-bit 1cas/2we: cas, low we, high we
// - 8-bit: both column pins cas, write pin we
// - 16-bit: address bit 0 picks lower/upper strobe
// - page codes 0 to 3 valid, rest reserved
// - row phase outputs page-size address slice
// - page hit compares upper bits, bus dependent
// - even bytes lower lane, odd upper on 16-bit
// - only areas 4 and 5, enabled per area
// - control bit selects strobe arrangement
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module dram_strobe_map (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic access_area5_i,
  input wire logic row_phase_i,
  input wire logic column_phase_i,
  input wire logic access_write_i,
  input wire logic [31:0] access_addr_i,
  output logic [31:0] dram_addr_o,
  output logic page_hit_o,
  output logic area4_row_strobe_pin_n_o,
  output logic area5_row_strobe_pin_n_o,
  output logic area4_low_column_select_pin_n_o,
  output logic area4_high_column_select_pin_n_o,
  output logic area5_low_column_select_pin_n_o,
  output logic area5_high_column_select_pin_n_o,
  output logic area4_dram_write_pin_n_o,
  output logic area5_dram_write_pin_n_o,
  output logic lower_lane_write_strobe_n_o,
  output logic upper_lane_write_strobe_n_o
);

  typedef enum logic [2:0] {
    bus_idle = 3'h1,
    bus_ack = 3'h2,
    bus_wait = 3'h4
  } bus_state_type;

  dram_map_pkg::control_type area4_dram_control;
  dram_map_pkg::control_type area5_dram_control;
  dram_map_pkg::control_type next_area4_dram_control;
  dram_map_pkg::control_type next_area5_dram_control;
  dram_map_pkg::control_type active;
  bus_state_type bus_state;
  bus_state_type next_bus_state;
  logic [31:0] next_dat;
  logic reserved_seen;
  logic next_reserved_seen;
  logic next_page_hit;
  logic [31:0] next_dram_addr;
  logic [31:0] last_addr [dram_map_pkg::area_count];
  logic [31:0] next_last_addr [dram_map_pkg::area_count];
  logic [dram_map_pkg::area_count-1:0] last_valid;
  logic [dram_map_pkg::area_count-1:0] next_last_valid;
  dram_map_pkg::area_pins_type pins [dram_map_pkg::area_count];
  dram_map_pkg::area_pins_type next_pins [dram_map_pkg::area_count];
  logic next_lower_lane;
  logic next_upper_lane;
  logic lower_lane;
  logic upper_lane;
  logic code_ok;
  logic [4:0] row_shift;
  logic [4:0] cmp_shift;
  logic [31:0] diff;
  logic idx;
  logic sel_lo;
  logic sel_hi;
  logic take;

  // register bus: one wait state, ack for one cycle, then released
  always_comb
  begin
    take = cyc_i && stb_i && (bus_state == bus_idle);
    next_bus_state = bus_state;
    next_dat = dat_o;
    next_area4_dram_control = area4_dram_control;
    next_area5_dram_control = area5_dram_control;
    case (bus_state)
      bus_idle:
      begin
        if (take)
        begin
          next_bus_state = bus_ack;
        end
      end
      bus_ack:
      begin
        next_bus_state = bus_wait;
      end
      bus_wait:
      begin
        if (!(cyc_i && stb_i))
        begin
          next_bus_state = bus_idle;
        end
      end
      default:
      begin
        next_bus_state = bus_idle;
      end
    endcase
    if (take)
    begin
      case (adr_i)
        dram_map_pkg::area4_control_offset:
        begin
          next_dat = {24'h000000, area4_dram_control};
          if (we_i && sel_i[0])
          begin
            next_area4_dram_control = dat_i[7:0];
          end
        end
        dram_map_pkg::area5_control_offset:
        begin
          next_dat = {24'h000000, area5_dram_control};
          if (we_i && sel_i[0])
          begin
            next_area5_dram_control = dat_i[7:0];
          end
        end
        dram_map_pkg::status_offset:
        begin
          next_dat = {30'h00000000, reserved_seen, page_hit_o};
        end
        default:
        begin
          next_dat = 32'h00000000;
        end
      endcase
    end
  end

  assign ack_o = (bus_state == bus_ack);

  // datapath: pick the area, slice the address, map the strobes
  always_comb
  begin
    idx = access_area5_i;
    active = idx ? area5_dram_control : area4_dram_control;
    code_ok = 1'b1;
    case (active.page_size_select)
      dram_map_pkg::page_256:
      begin
        row_shift = dram_map_pkg::shift_256;
      end
      dram_map_pkg::page_512:
      begin
        row_shift = dram_map_pkg::shift_512;
      end
      dram_map_pkg::page_1024:
      begin
        row_shift = dram_map_pkg::shift_1024;
      end
      dram_map_pkg::page_4096:
      begin
        row_shift = dram_map_pkg::shift_4096;
      end
      default:
      begin
        row_shift = dram_map_pkg::shift_256;
        code_ok = 1'b0;
      end
    endcase
    cmp_shift = active.narrow_bus ? row_shift : row_shift + 5'h01;
    diff = (access_addr_i ^ last_addr[idx]) >> cmp_shift;
    next_page_hit = page_hit_o;
    next_dram_addr = dram_addr_o;
    next_last_addr = last_addr;
    next_last_valid = last_valid;
    next_reserved_seen = reserved_seen;
    if (take && we_i && (adr_i == dram_map_pkg::status_offset) && sel_i[0]
        && dat_i[dram_map_pkg::reserved_seen_bit])
    begin
      next_reserved_seen = 1'b0;
    end
    if ((row_phase_i || column_phase_i) && active.dram_area_enable && !code_ok)
    begin
      next_reserved_seen = 1'b1;
    end
    if (row_phase_i && active.dram_area_enable && code_ok)
    begin
      // row slice on low address lines
      next_dram_addr = {access_addr_i[31:16], 16'(access_addr_i >> row_shift)};
      next_page_hit = active.page_mode && last_valid[idx] && (diff == 32'h00000000);
      next_last_addr[idx] = access_addr_i;
      next_last_valid[idx] = 1'b1;
    end
    else if (column_phase_i && active.dram_area_enable && code_ok)
    begin
      next_dram_addr = access_addr_i;
    end
    for (int a = 0; a < dram_map_pkg::area_count; a++)
    begin
      next_pins[a] = dram_map_pkg::pins_idle;
    end
    next_lower_lane = 1'b0;
    next_upper_lane = 1'b0;
    sel_lo = !access_addr_i[0];
    sel_hi = access_addr_i[0];
    if ((row_phase_i || column_phase_i) && active.dram_area_enable && code_ok)
    begin
      // row strobe of the selected area
      next_pins[idx].row_strobe_n = 1'b0;
      if (column_phase_i)
      begin
        if (active.narrow_bus)
        begin
          // both column pins as one cas
          next_pins[idx].low_column_select_n = 1'b0;
          next_pins[idx].high_column_select_n = 1'b0;
          next_pins[idx].dram_write_n = !access_write_i;
          next_lower_lane = access_write_i;
        end
        else
        begin
          if (active.one_cas_two_we)
          begin
            next_pins[idx].low_column_select_n = 1'b0;
            next_pins[idx].high_column_select_n = !(access_write_i && sel_lo);
            next_pins[idx].dram_write_n = !(access_write_i && sel_hi);
          end
          else
          begin
            next_pins[idx].low_column_select_n = !sel_lo;
            next_pins[idx].high_column_select_n = !sel_hi;
            next_pins[idx].dram_write_n = !access_write_i;
          end
          // even bytes lower lane, odd upper
          next_lower_lane = access_write_i && sel_lo;
          next_upper_lane = access_write_i && sel_hi;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_state <= bus_idle;
      dat_o <= 32'h00000000;
      area4_dram_control <= dram_map_pkg::control_reset;
      area5_dram_control <= dram_map_pkg::control_reset;
      reserved_seen <= 1'b0;
      page_hit_o <= 1'b0;
      dram_addr_o <= 32'h00000000;
      last_valid <= '0;
      lower_lane <= 1'b0;
      upper_lane <= 1'b0;
      for (int a = 0; a < dram_map_pkg::area_count; a++)
      begin
        last_addr[a] <= 32'h00000000;
        pins[a] <= dram_map_pkg::pins_idle;
      end
    end
    else
    begin
      bus_state <= next_bus_state;
      dat_o <= next_dat;
      area4_dram_control <= next_area4_dram_control;
      area5_dram_control <= next_area5_dram_control;
      reserved_seen <= next_reserved_seen;
      page_hit_o <= next_page_hit;
      dram_addr_o <= next_dram_addr;
      last_valid <= next_last_valid;
      lower_lane <= next_lower_lane;
      upper_lane <= next_upper_lane;
      for (int a = 0; a < dram_map_pkg::area_count; a++)
      begin
        last_addr[a] <= next_last_addr[a];
        pins[a] <= next_pins[a];
      end
    end
  end

  assign area4_row_strobe_pin_n_o = pins[0].row_strobe_n;
  assign area5_row_strobe_pin_n_o = pins[1].row_strobe_n;
  assign area4_low_column_select_pin_n_o = pins[0].low_column_select_n;
  assign area4_high_column_select_pin_n_o = pins[0].high_column_select_n;
  assign area5_low_column_select_pin_n_o = pins[1].low_column_select_n;
  assign area5_high_column_select_pin_n_o = pins[1].high_column_select_n;
  assign area4_dram_write_pin_n_o = pins[0].dram_write_n;
  assign area5_dram_write_pin_n_o = pins[1].dram_write_n;
  assign lower_lane_write_strobe_n_o = !lower_lane;
  assign upper_lane_write_strobe_n_o = !upper_lane;

endmodule : dram_strobe_map

//--- shared/dram_map_pkg.sv
// constants and carrier types for the dram strobe map and page address block
package dram_map_pkg;

  localparam logic [7:0] area4_control_offset = 8'h00;
  localparam logic [7:0] area5_control_offset = 8'h04;
  localparam logic [7:0] status_offset = 8'h08;

  localparam int enable_bit = 0;
  localparam int arrangement_bit = 1;
  localparam int page_mode_bit = 2;
  localparam int narrow_bus_bit = 3;
  localparam int page_size_lsb = 4;
  localparam int page_size_msb = 7;

  localparam int page_hit_bit = 0;
  localparam int reserved_seen_bit = 1;

  localparam logic [7:0] control_reset = 8'h00;

  localparam logic [3:0] page_256 = 4'h0;
  localparam logic [3:0] page_512 = 4'h1;
  localparam logic [3:0] page_1024 = 4'h2;
  localparam logic [3:0] page_4096 = 4'h3;

  localparam logic [4:0] shift_256 = 5'h08;
  localparam logic [4:0] shift_512 = 5'h09;
  localparam logic [4:0] shift_1024 = 5'h0a;
  localparam logic [4:0] shift_4096 = 5'h0c;

  localparam int area_count = 2;

  typedef struct packed {
    logic [3:0] page_size_select;
    logic narrow_bus;
    logic page_mode;
    logic one_cas_two_we;
    logic dram_area_enable;
  } control_type;

  typedef struct packed {
    logic row_strobe_n;
    logic low_column_select_n;
    logic high_column_select_n;
    logic dram_write_n;
  } area_pins_type;

  localparam area_pins_type pins_idle = 4'hf;

endpackage : dram_map_pkg

//--- tb/dram_strobe_map_chk.sv
// checker for the dram strobe map block
`timescale 1ns/1ps
module dram_strobe_map_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic row_phase_i,
  input wire logic column_phase_i,
  input wire logic access_area5_i,
  input wire logic access_write_i,
  input wire logic [31:0] access_addr_i,
  input logic [31:0] dram_addr_o,
  input logic area4_row_strobe_pin_n_o,
  input logic area5_row_strobe_pin_n_o,
  input logic lower_lane_write_strobe_n_o,
  input logic upper_lane_write_strobe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_row;
    row_phase_i;
  endsequence
  sequence s_col;
    column_phase_i && !row_phase_i;
  endsequence
  AST_ROW4: assert property (!area4_row_strobe_pin_n_o |->
    $past(row_phase_i || column_phase_i) && !$past(access_area5_i)) else $error("area 4 row strobe stray");
  AST_ROW5: assert property (!area5_row_strobe_pin_n_o |->
    $past(row_phase_i || column_phase_i) && $past(access_area5_i)) else $error("area 5 row strobe stray");
  AST_ONE_AREA: assert property (area4_row_strobe_pin_n_o || area5_row_strobe_pin_n_o)
    else $error("both row strobes low");
  AST_LANE_HIGH: assert property (!upper_lane_write_strobe_n_o |->
    $past(access_addr_i[0]) && $past(column_phase_i)) else $error("upper lane on even byte");
  AST_LANE_ONE: assert property (lower_lane_write_strobe_n_o || upper_lane_write_strobe_n_o)
    else $error("both lanes strobed");
  AST_LANE_WR: assert property (!(lower_lane_write_strobe_n_o && upper_lane_write_strobe_n_o) |->
    $past(access_write_i)) else $error("lane strobe on read");
  AST_COL_ADDR: assert property (s_col ##1 !(area4_row_strobe_pin_n_o && area5_row_strobe_pin_n_o) |->
    dram_addr_o == $past(access_addr_i)) else $error("column address wrong");
  AST_ROW_HIGH: assert property (s_row ##1 !(area4_row_strobe_pin_n_o && area5_row_strobe_pin_n_o) |->
    dram_addr_o[31:16] == $past(access_addr_i[31:16])) else $error("row upper address wrong");
endmodule : dram_strobe_map_chk

bind dram_strobe_map dram_strobe_map_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .row_phase_i(row_phase_i),
  .column_phase_i(column_phase_i), .access_area5_i(access_area5_i), .access_write_i(access_write_i),
  .access_addr_i(access_addr_i), .dram_addr_o(dram_addr_o), .area4_row_strobe_pin_n_o(area4_row_strobe_pin_n_o),
  .area5_row_strobe_pin_n_o(area5_row_strobe_pin_n_o), .lower_lane_write_strobe_n_o(lower_lane_write_strobe_n_o),
  .upper_lane_write_strobe_n_o(upper_lane_write_strobe_n_o));

//--- tb/dram_partner.sv
// behavioural pair of dram banks latching row and column addresses
`timescale 1ns/1ps
module dram_partner (
  input wire logic clk_i,
  input wire logic [1:0] row_n_i,
  input wire logic [1:0] col_n_i,
  input wire logic [31:0] addr_i,
  output logic [63:0] row_o,
  output logic [63:0] col_o
);
  logic [1:0] row_q = 2'b11;
  always @(posedge clk_i)
  begin
    for (int b = 0; b < 2; b++)
    begin
      if (!row_n_i[b] && row_q[b])
        row_o[b*32 +: 32] <= addr_i;
      if (!col_n_i[b] && !row_n_i[b])
        col_o[b*32 +: 32] <= addr_i;
    end
    row_q <= row_n_i;
  end
endmodule : dram_partner

//--- tb/dram_strobe_map_tb_top.sv
// self-checking bench for the dram strobe map block
`timescale 1ns/1ps
module dram_strobe_map_tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, a5 = 0, row = 0, col = 0, wr = 0, h = 0;
  logic ack, hit, rs4, rs5, l4, h4, l5, h5, w4, w5, lw, uw;
  logic [7:0] adr = 8'h00, c;
  logic [3:0] sel = 4'h1;
  logic [31:0] dat = 32'h0, ad = 32'h0, rdat, da, r, s = 32'hb3a0;
  logic [31:0] prev [2];
  bit have [2];
  logic [31:0] rq [$];
  logic [42:0] pq [$];
  int err_count = 0, n_tests = 0, md, pg, sh;
  dram_strobe_map i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(rdat), .ack_o(ack), .access_area5_i(a5), .row_phase_i(row), .column_phase_i(col),
    .access_write_i(wr), .access_addr_i(ad), .dram_addr_o(da), .page_hit_o(hit),
    .area4_row_strobe_pin_n_o(rs4), .area5_row_strobe_pin_n_o(rs5), .area4_low_column_select_pin_n_o(l4),
    .area4_high_column_select_pin_n_o(h4), .area5_low_column_select_pin_n_o(l5),
    .area5_high_column_select_pin_n_o(h5), .area4_dram_write_pin_n_o(w4), .area5_dram_write_pin_n_o(w5),
    .lower_lane_write_strobe_n_o(lw), .upper_lane_write_strobe_n_o(uw));
  dram_partner i_mem (.clk_i(clk_i), .row_n_i({rs5, rs4}), .col_n_i({l5 & h5, l4 & h4}), .addr_i(da),
    .row_o(), .col_o());
  initial
    forever #50 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [42:0] ex(bit s5, bit cp, bit w, logic [31:0] a);
    logic [3:0] p;
    logic [1:0] ln;
    logic [7:0] v;
    logic [31:0] d;
    p = 4'h8;
    ln = 2'b00;
    d = {a[31:16], 16'(a >> sh)};
    if (cp)
    begin
      d = a;
      p = md == 0 ? {1'b1, !a[0], a[0], w} : md == 1 ? {2'b11, w & !a[0], w & a[0]} : {3'b111, w};
      ln = !w ? 2'b00 : md == 2 ? 2'b10 : {!a[0], a[0]};
    end
    v = s5 ? {1'b0, p[3], 2'b00, p[2:1], 1'b0, p[0]} : {p[3], 1'b0, p[2:1], 2'b00, p[0], 1'b0};
    return {~v, ~ln, h, d};
  endfunction : ex
  task note(input string nm, input logic [42:0] e, input logic [42:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : note
  task chk_rd(input logic [31:0] e, input logic [31:0] g);
    note("read data", {11'h0, e}, {11'h0, g});
  endtask : chk_rd
  task chk_pin(input logic [42:0] e, input logic [42:0] g);
    note("pins hit address", e, g);
  endtask : chk_pin
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0)
      chk_rd(rq.pop_front(), rdat);
    if (!rst_i && (rs4 & rs5 & lw & uw) !== 1'b1)
      chk_pin(pq.size() ? pq.pop_front() : 'x, {rs4, rs5, l4, h4, l5, h5, w4, w5, lw, uw, hit, da});
  end
  task wb(input bit w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
    if (n >= 20)
      err_count++;
    cyc <= 0;
    stb <= 0;
  endtask : wb
  task rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(0, a, 8'h00);
  endtask : rd
  task acc(input bit s5, input logic [31:0] a, input bit take);
    bit w;
    w = xs() % 2;
    @(posedge clk_i);
    a5 <= s5;
    wr <= w;
    ad <= a;
    row <= 1;
    if (take)
    begin
      h = (pg != 1) && have[s5] && ((a ^ prev[s5]) >> (sh + (md != 2))) == 0;
      prev[s5] = a;
      have[s5] = 1;
      pq.push_back(ex(s5, 0, w, a));
    end
    @(posedge clk_i);
    row <= 0;
    col <= 1;
    if (take)
      pq.push_back(ex(s5, 1, w, a));
    @(posedge clk_i);
    col <= 0;
  endtask : acc
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #2000000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    for (md = 0; md < 3; md++)
      for (pg = 0; pg < 4; pg++)
        for (int k = 0; k < 2; k++)
        begin
          sh = pg == 3 ? 12 : 8 + pg;
          c = {pg[3:0], md == 2, pg != 1, md == 1, 1'b1};
          wb(1, k ? 8'h04 : 8'h00, c);
          rd(k ? 8'h04 : 8'h00, {24'h0, c});
          r = xs();
          acc(k, r, 1);
          acc(k, {r[31:8], 8'(xs())}, 1);
        end
    $display("test strobe map and page address done");
    wb(1, 8'h00, 8'h45);
    acc(0, xs(), 0);
    rd(8'h08, {30'h0, 1'b1, h});
    wb(1, 8'h08, 8'h02);
    rd(8'h08, {31'h0, h});
    sel <= 4'he;
    wb(1, 8'h00, 8'h00);
    sel <= 4'h1;
    rd(8'h00, 32'h45);
    wb(1, 8'h0c, 8'hff);
    rd(8'h0c, 32'h0);
    wb(1, 8'h04, 8'h00);
    acc(1, xs(), 0);
    rd(8'h04, 32'h0);
    $display("test reserved, unmapped and disabled done");
    repeat (3) @(posedge clk_i);
    report_and_stop();
  end
endmodule : dram_strobe_map_tb_top
